/* File: crt_monitor.sv */
// Behavioural monitor model that measures the horizontal pulses it receives.
`timescale 1ns/1ps
module crt_monitor (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        hblank_i,
	input  wire logic        hsync_i,
	input  wire logic        left_border_i,
	output logic      [15:0] line_len_o,
	output logic      [15:0] blank_w_o,
	output logic      [15:0] sync_w_o,
	output logic      [15:0] border_w_o,
	output logic      [15:0] sync_lag_o,
	output logic      [15:0] overlap_o
);
	// ----------------------------------------------------------------
	// Edge timestamps
	// ----------------------------------------------------------------
	// A monitor only sees levels, so every width is a distance between edges; overlap_o counts blank ends seen during sync.
	logic [15:0] cyc;
	logic [15:0] t_sync;
	logic [15:0] t_blank;
	logic [15:0] t_border;
	logic        hb_q;
	logic        hs_q;
	logic        lb_q;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			{cyc, t_sync, t_blank, t_border, hb_q, hs_q, lb_q} <= '0;
			{line_len_o, blank_w_o, sync_w_o, border_w_o, sync_lag_o, overlap_o} <= '0;
		end else begin
			cyc  <= cyc + 16'h0001;
			hb_q <= hblank_i;
			hs_q <= hsync_i;
			lb_q <= left_border_i;
			if (hsync_i && !hs_q) begin
				line_len_o <= cyc - t_sync;
				sync_lag_o <= cyc - t_blank;
				t_sync     <= cyc;
			end
			if (!hsync_i && hs_q)
				sync_w_o <= cyc - t_sync;
			if (hblank_i && !hb_q)
				t_blank <= cyc;
			if (!hblank_i && hb_q) begin
				blank_w_o <= cyc - t_blank;
				if (hsync_i)
					overlap_o <= overlap_o + 16'h0001;
			end
			if (left_border_i && !lb_q)
				t_border <= cyc;
			if (!left_border_i && lb_q)
				border_w_o <= cyc - t_border;
		end
	end
endmodule : crt_monitor

/* File: hblank_hsync_timing.sv */
// Horizontal blank and retrace timing generator with its working-set registers.
//
// Notes on behaviour
// R1 - Blank-end extension bit 7 is blank start bit 8, above the low byte.
// R2 - Blank end is six bits: extension bits 4:0 plus retrace-end bit 7.
// R3 - Blanking ends when low count bits match blank end; at most 64 clocks.
// R4 - Software sets blank end to blank start low bits plus blanking width.
// R5 - Software should end blanking one clock before display restarts.
// R6 - Clocks between blanking end and display start form the left border.
// R7 - Sync starts at a 9-bit position: low byte plus retrace-end bit 6.
// R8 - Retrace-end bit 5 is bit 8 of the horizontal total.
// R9 - Sync ends when low five count bits match retrace-end bits 4:0.
// R10 - Software sets retrace end to start low bits plus sync width.
// R11 - Software makes sync end before blanking ends.
// R12 - Blanking starts when the counter reaches the 9-bit blank start.
// R13 - Select low: standard sync-start writes (index 04) also load the set; high: extension path only.
// R14 - Blank-end extension bits 6 and 5 ignore writes and read zero.
`timescale 1ns/1ps
module hblank_hsync_timing (
	input  wire logic                           clock_i,
	input  wire logic                           rst_i,
	input  wire horizontal_timing_pkg::io_req_t io_req_i,
	input  wire logic                           working_set_select_i,
	input  wire logic [7:0]                     htotal_low_i,
	input  wire logic [7:0]                     hblank_start_low_i,
	output logic [7:0]                          io_rdata_o,
	output logic                                hblank_o,
	output logic                                hsync_o,
	output logic                                left_border_o
);

	// ----------------------------------------------------------------
	// Register port decode
	// ----------------------------------------------------------------
	logic [7:0] ext_index;
	logic [7:0] crtc_index;
	logic [7:0] hblank_end_extension;
	logic [7:0] hsync_start_low;
	logic [7:0] hsync_end_extension;
	logic [horizontal_timing_pkg::COUNT_W-1:0] char_count;

	wire logic       ext_index_wr;
	wire logic       ext_data_wr;
	wire logic       ext_data_rd;
	wire logic       ext_index_rd;
	wire logic       crtc_index_wr;
	wire logic       crtc_data_wr;
	wire logic       std_sync_wr;
	wire logic       wr_blank_ext;
	wire logic       wr_sync_low;
	wire logic       wr_sync_ext;
	wire logic [7:0] next_hblank_end_extension;
	wire logic [7:0] next_hsync_start_low;
	wire logic [7:0] next_hsync_end_extension;
	wire logic [7:0] ext_read_value;
	wire logic [7:0] next_io_rdata;

	assign ext_index_wr  = io_req_i.wr && (io_req_i.addr == horizontal_timing_pkg::EXT_INDEX_PORT);
	assign ext_index_rd  = io_req_i.rd && (io_req_i.addr == horizontal_timing_pkg::EXT_INDEX_PORT);
	assign ext_data_wr   = io_req_i.wr && (io_req_i.addr == horizontal_timing_pkg::EXT_DATA_PORT);
	assign ext_data_rd   = io_req_i.rd && (io_req_i.addr == horizontal_timing_pkg::EXT_DATA_PORT);
	assign crtc_index_wr = io_req_i.wr
		&& ((io_req_i.addr == horizontal_timing_pkg::CRTC_INDEX_MONO)
		|| (io_req_i.addr == horizontal_timing_pkg::CRTC_INDEX_COL));
	assign crtc_data_wr  = io_req_i.wr
		&& ((io_req_i.addr == horizontal_timing_pkg::CRTC_DATA_MONO)
		|| (io_req_i.addr == horizontal_timing_pkg::CRTC_DATA_COL));

	// The standard copy itself lives in the CRTC; this only mirrors it into the working set.
	assign std_sync_wr = crtc_data_wr && !working_set_select_i
		&& (crtc_index == horizontal_timing_pkg::IDX_STANDARD_HSYNC_START); // R13

	assign wr_blank_ext = ext_data_wr && (ext_index == horizontal_timing_pkg::IDX_HBLANK_END_EXTENSION);
	assign wr_sync_low  = ext_data_wr && (ext_index == horizontal_timing_pkg::IDX_HSYNC_START_LOW);
	assign wr_sync_ext  = ext_data_wr && (ext_index == horizontal_timing_pkg::IDX_HSYNC_END_EXTENSION);

	assign next_hblank_end_extension = wr_blank_ext
		? (io_req_i.wdata & horizontal_timing_pkg::HBLANK_END_EXT_MASK) // R14
		: hblank_end_extension;
	assign next_hsync_start_low = (wr_sync_low || std_sync_wr) ? io_req_i.wdata
		: hsync_start_low; // R13
	assign next_hsync_end_extension = wr_sync_ext ? io_req_i.wdata : hsync_end_extension;

	assign ext_read_value =
		(ext_index == horizontal_timing_pkg::IDX_HBLANK_END_EXTENSION) ? hblank_end_extension :
		(ext_index == horizontal_timing_pkg::IDX_HSYNC_START_LOW)      ? hsync_start_low :
		(ext_index == horizontal_timing_pkg::IDX_HSYNC_END_EXTENSION)  ? hsync_end_extension :
		8'h00;
	assign next_io_rdata = ext_data_rd ? ext_read_value : (ext_index_rd ? ext_index : io_rdata_o);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ext_index  <= horizontal_timing_pkg::INDEX_RESET;
			crtc_index <= horizontal_timing_pkg::INDEX_RESET;
		end else begin
			ext_index  <= ext_index_wr ? io_req_i.wdata : ext_index;
			crtc_index <= crtc_index_wr ? io_req_i.wdata : crtc_index;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			hblank_end_extension <= horizontal_timing_pkg::HBLANK_END_EXT_RESET;
			hsync_start_low      <= horizontal_timing_pkg::HSYNC_START_RESET;
			hsync_end_extension  <= horizontal_timing_pkg::HSYNC_END_EXT_RESET;
			io_rdata_o           <= horizontal_timing_pkg::RDATA_RESET;
		end else begin
			hblank_end_extension <= next_hblank_end_extension;
			hsync_start_low      <= next_hsync_start_low;
			hsync_end_extension  <= next_hsync_end_extension;
			io_rdata_o           <= next_io_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Timing fields
	// ----------------------------------------------------------------
	wire logic [horizontal_timing_pkg::POS_W-1:0]       blank_start;
	wire logic [horizontal_timing_pkg::BLANK_END_W-1:0] blank_end;
	wire logic [horizontal_timing_pkg::POS_W-1:0]       sync_start;
	wire logic [horizontal_timing_pkg::SYNC_END_W-1:0]  sync_end;
	wire logic [horizontal_timing_pkg::POS_W-1:0]       htotal;
	wire logic [horizontal_timing_pkg::COUNT_W-1:0]     line_last;

	assign blank_start = {hblank_end_extension[horizontal_timing_pkg::HBLANK_START_BIT8_POS],
		hblank_start_low_i}; // R1
	assign blank_end   = {hsync_end_extension[horizontal_timing_pkg::HBLANK_END_BIT5_POS],
		hblank_end_extension[horizontal_timing_pkg::HBLANK_END_LOW_MSB:0]}; // R2
	assign sync_start  = {hsync_end_extension[horizontal_timing_pkg::HSYNC_START_BIT8_POS],
		hsync_start_low}; // R7
	assign sync_end    = hsync_end_extension[horizontal_timing_pkg::HSYNC_END_MSB:0]; // R9
	assign htotal      = {hsync_end_extension[horizontal_timing_pkg::HTOTAL_BIT8_POS],
		htotal_low_i}; // R8

	// The total is programmed as characters minus five, so the count runs 0 to total+4.
	// Counting to ten bits keeps a total of 511 from overflowing.
	assign line_last = {1'b0, htotal} + horizontal_timing_pkg::HTOTAL_LAST_ADJUST;

	// ----------------------------------------------------------------
	// Character counter, clock_i being the character clock
	// ----------------------------------------------------------------
	wire logic                                      count_wrap;
	wire logic [horizontal_timing_pkg::COUNT_W-1:0] next_char_count;

	// Greater-or-equal recovers at once if software shrinks the total mid-line.
	assign count_wrap      = (char_count >= line_last);
	assign next_char_count = count_wrap ? horizontal_timing_pkg::COUNT_RESET
		: char_count + 10'h001;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			char_count <= horizontal_timing_pkg::COUNT_RESET;
		end else begin
			char_count <= next_char_count;
		end
	end

	// ----------------------------------------------------------------
	// Blank and sync pulses
	// ----------------------------------------------------------------
	window_pulse #(
		.END_W(horizontal_timing_pkg::BLANK_END_W)
	) blank_pulse (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.count_i  (char_count),
		.start_i  (blank_start),
		.end_i    (blank_end),
		.active_o (hblank_o)
	); // R3 R12

	window_pulse #(
		.END_W(horizontal_timing_pkg::SYNC_END_W)
	) sync_pulse (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.count_i  (char_count),
		.start_i  (sync_start),
		.end_i    (sync_end),
		.active_o (hsync_o)
	); // R7 R9

	// ----------------------------------------------------------------
	// Left border
	// ----------------------------------------------------------------
	wire logic blank_start_hit;
	wire logic blank_end_event;
	wire logic next_left_border;

	assign blank_start_hit = (char_count == {1'b0, blank_start});
	assign blank_end_event = hblank_o && !blank_start_hit
		&& (char_count[horizontal_timing_pkg::BLANK_END_W-1:0] == blank_end);
	// Active display begins at count zero, so the border closes on the wrap.
	assign next_left_border = (count_wrap || blank_start_hit) ? 1'b0
		: (blank_end_event ? 1'b1 : left_border_o); // R6

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			left_border_o <= 1'b0;
		end else begin
			left_border_o <= next_left_border;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence std_sync_write_s;
		io_req_i.wr && !working_set_select_i
			&& (crtc_index == horizontal_timing_pkg::IDX_STANDARD_HSYNC_START)
			&& ((io_req_i.addr == horizontal_timing_pkg::CRTC_DATA_COL)
			|| (io_req_i.addr == horizontal_timing_pkg::CRTC_DATA_MONO));
	endsequence

	chk_reserved_bits_zero: assert property (@(posedge clock_i) disable iff (rst_i) // R14
		hblank_end_extension[6:5] == 2'b00) else $error("reserved bits not zero");
	chk_std_path_mirror: assert property (@(posedge clock_i) disable iff (rst_i) // R13
		std_sync_write_s |=> hsync_start_low == $past(io_req_i.wdata))
		else $error("standard write not mirrored");
	chk_std_path_blocked: assert property (@(posedge clock_i) disable iff (rst_i) // R13
		crtc_data_wr && working_set_select_i && !ext_data_wr |=> $stable(hsync_start_low))
		else $error("standard write reached working set");
	chk_blank_start_pos: assert property (@(posedge clock_i) disable iff (rst_i) // R1
		char_count == {1'b0, hblank_end_extension[7], hblank_start_low_i} |=> hblank_o)
		else $error("blanking did not start at 9-bit position");
	chk_blank_end_match: assert property (@(posedge clock_i) disable iff (rst_i) // R2
		hblank_o && !blank_start_hit
		&& char_count[5:0] == {hsync_end_extension[7], hblank_end_extension[4:0]}
		|=> !hblank_o) else $error("blanking did not end on 6-bit match");
	chk_sync_start_pos: assert property (@(posedge clock_i) disable iff (rst_i) // R7
		char_count == {1'b0, hsync_end_extension[6], hsync_start_low} |=> hsync_o)
		else $error("sync did not start at 9-bit position");
	chk_total_wrap: assert property (@(posedge clock_i) disable iff (rst_i) // R8
		char_count == {1'b0, hsync_end_extension[5], htotal_low_i} + 10'h004
		|=> char_count == 10'h000) else $error("line did not wrap at total");
	chk_border_after_blank: assert property (@(posedge clock_i) disable iff (rst_i) // R6
		blank_end_event && !count_wrap |=> left_border_o ##1 (left_border_o || $past(count_wrap)
		|| $past(blank_start_hit))) else $error("left border not opened after blanking");
	chk_sync_end_match: assert property (@(posedge clock_i) disable iff (rst_i) // R9
		hsync_o && char_count[4:0] == hsync_end_extension[4:0]
		&& char_count != {1'b0, sync_start} |=> !hsync_o)
		else $error("sync did not end on 5-bit match");

endmodule : hblank_hsync_timing

/* File: horizontal_timing_pkg.sv */
// Shared constants and types for the horizontal blank and retrace timing block.
package horizontal_timing_pkg;

	// ----------------------------------------------------------------
	// I/O port addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] EXT_INDEX_PORT  = 16'h03CE;
	localparam logic [15:0] EXT_DATA_PORT   = 16'h03CF;
	localparam logic [15:0] CRTC_INDEX_MONO = 16'h03B4;
	localparam logic [15:0] CRTC_DATA_MONO  = 16'h03B5;
	localparam logic [15:0] CRTC_INDEX_COL  = 16'h03D4;
	localparam logic [15:0] CRTC_DATA_COL   = 16'h03D5;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_HBLANK_END_EXTENSION = 8'h62;
	localparam logic [7:0] IDX_HSYNC_START_LOW      = 8'h63;
	localparam logic [7:0] IDX_HSYNC_END_EXTENSION  = 8'h64;
	localparam logic [7:0] IDX_STANDARD_HTOTAL      = 8'h00;
	localparam logic [7:0] IDX_STANDARD_HSYNC_START = 8'h04;

	// ----------------------------------------------------------------
	// Field positions and masks
	// ----------------------------------------------------------------
	localparam int          HBLANK_START_BIT8_POS = 7;
	localparam int          HBLANK_END_BIT5_POS   = 7;
	localparam int          HSYNC_START_BIT8_POS  = 6;
	localparam int          HTOTAL_BIT8_POS       = 5;
	localparam int          HBLANK_END_LOW_MSB    = 4;
	localparam int          HSYNC_END_MSB         = 4;
	localparam logic [7:0]  HBLANK_END_EXT_MASK   = 8'h9F;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0]  HBLANK_END_EXT_RESET  = 8'h00;
	localparam logic [7:0]  HSYNC_START_RESET     = 8'h00;
	localparam logic [7:0]  HSYNC_END_EXT_RESET   = 8'h00;
	localparam logic [7:0]  INDEX_RESET           = 8'h00;
	localparam logic [7:0]  RDATA_RESET           = 8'h00;
	localparam int          COUNT_W               = 10;
	localparam int          POS_W                 = 9;
	localparam int          BLANK_END_W           = 6;
	localparam int          SYNC_END_W            = 5;
	localparam logic [9:0]  HTOTAL_LAST_ADJUST    = 10'h004;
	localparam logic [9:0]  COUNT_RESET           = 10'h000;

	// ----------------------------------------------------------------
	// Host I/O request
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic        rd;
		logic [7:0]  wdata;
	} io_req_t;

endpackage : horizontal_timing_pkg

/* File: tb_hblank_hsync_timing.sv */
// Self-checking testbench for the horizontal blank and retrace timing block.
`timescale 1ns/1ps
module tb_hblank_hsync_timing;
	logic                           clock_i;
	logic                           rst_i;
	horizontal_timing_pkg::io_req_t io_req;
	logic                           sel;
	logic [7:0]                     htotal_low;
	logic [7:0]                     hb_start_low;
	logic [7:0]                     io_rdata;
	logic                           hblank;
	logic                           hsync;
	logic                           border;
	logic [15:0]                    line_len, blank_w, sync_w, border_w, sync_lag, overlap;
	int                             failures;
	int                             num_checks;

	hblank_hsync_timing hblank_hsync_timing_i (
		.clock_i(clock_i), .rst_i(rst_i), .io_req_i(io_req), .working_set_select_i(sel),
		.htotal_low_i(htotal_low), .hblank_start_low_i(hb_start_low), .io_rdata_o(io_rdata),
		.hblank_o(hblank), .hsync_o(hsync), .left_border_o(border));

	crt_monitor crt_monitor_i (
		.clock_i(clock_i), .rst_i(rst_i), .hblank_i(hblank), .hsync_i(hsync),
		.left_border_i(border), .line_len_o(line_len), .blank_w_o(blank_w),
		.sync_w_o(sync_w), .border_w_o(border_w), .sync_lag_o(sync_lag), .overlap_o(overlap));

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	// ----------------------------------------------------------------
	// Host port access
	// ----------------------------------------------------------------
	// Requests are one-cycle pulses launched just after an edge and dropped after the next.
	task automatic io_cycle(input logic [15:0] a, input logic w, input logic r, input logic [7:0] d);
		@(posedge clock_i);
		#1;
		io_req = '{a, w, r, d};
		@(posedge clock_i);
		#1;
		io_req.wr = 1'b0;
		io_req.rd = 1'b0;
	endtask : io_cycle

	task automatic ext_write(input logic [7:0] idx, input logic [7:0] d);
		io_cycle(horizontal_timing_pkg::EXT_INDEX_PORT, 1'b1, 1'b0, idx);
		io_cycle(horizontal_timing_pkg::EXT_DATA_PORT, 1'b1, 1'b0, d);
	endtask : ext_write

	task automatic ext_read(input logic [7:0] idx, input logic [7:0] exp);
		io_cycle(horizontal_timing_pkg::EXT_INDEX_PORT, 1'b1, 1'b0, idx);
		io_cycle(horizontal_timing_pkg::EXT_DATA_PORT, 1'b0, 1'b1, 8'h00);
		check({8'h00, io_rdata}, {8'h00, exp});
	endtask : ext_read

	task automatic crtc_write(input logic [15:0] ip, input logic [7:0] idx, input logic [7:0] d);
		io_cycle(ip, 1'b1, 1'b0, idx);
		io_cycle(ip + 16'h0001, 1'b1, 1'b0, d);
	endtask : crtc_write

	// Programs one line shape, lets three lines pass, then checks what the monitor saw.
	task automatic run_cfg(input logic [7:0] r62, input logic [7:0] r63, input logic [7:0] r64,
			input logic [7:0] tl, input logic [7:0] bl, input logic [15:0] exp[5]);
		htotal_low   = tl;
		hb_start_low = bl;
		// Sync end goes in before sync start, so that no half-programmed line
		// ends its blanking while a sync pulse is still running.
		ext_write(horizontal_timing_pkg::IDX_HBLANK_END_EXTENSION, r62);
		ext_write(horizontal_timing_pkg::IDX_HSYNC_END_EXTENSION, r64);
		ext_write(horizontal_timing_pkg::IDX_HSYNC_START_LOW, r63);
		repeat (3 * exp[0] + 10) @(posedge clock_i);
		#1;
		check(line_len, exp[0]);
		check(blank_w, exp[1]);
		check(sync_w, exp[2]);
		check(sync_lag, exp[3]);
		check(border_w, exp[4]);
		check(overlap, 16'h0000);
	endtask : run_cfg

	// ----------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	initial begin
		repeat (20000) @(posedge clock_i);
		failures++;
		complete_run();
	end

	initial begin
		failures     = 0;
		num_checks   = 0;
		rst_i        = 1'b1;
		io_req       = '0;
		sel          = 1'b1;
		htotal_low   = 8'h00;
		hb_start_low = 8'h00;
		repeat (6) @(posedge clock_i);
		#1;
		check({13'h0000, hblank, hsync, border}, 16'h0000);
		rst_i = 1'b0;
		ext_read(horizontal_timing_pkg::IDX_HBLANK_END_EXTENSION, 8'h00);
		ext_read(horizontal_timing_pkg::IDX_HSYNC_START_LOW, 8'h00);
		ext_read(horizontal_timing_pkg::IDX_HSYNC_END_EXTENSION, 8'h00);
		ext_write(horizontal_timing_pkg::IDX_HBLANK_END_EXTENSION, 8'hFF);
		ext_read(horizontal_timing_pkg::IDX_HBLANK_END_EXTENSION, 8'h9F);
		ext_write(horizontal_timing_pkg::IDX_HSYNC_START_LOW, 8'hA5);
		ext_read(horizontal_timing_pkg::IDX_HSYNC_START_LOW, 8'hA5);
		ext_read(8'h0E, 8'h00);
		// Short line: total field 10, blank 8 to 12, sync 9 to 11.
		run_cfg(8'h0C, 8'h09, 8'h0B, 8'h0A, 8'h08, '{16'd15, 16'd4, 16'd2, 16'd1, 16'd2});
		// Every ninth and sixth bit set: blank 105h plus 40, sync 106h plus 20, total 140h.
		run_cfg(8'h8D, 8'h06, 8'hFA, 8'h40, 8'h05, '{16'd325, 16'd40, 16'd20, 16'd1, 16'd23});
		ext_read(horizontal_timing_pkg::IDX_HSYNC_END_EXTENSION, 8'hFA);
		crtc_write(horizontal_timing_pkg::CRTC_INDEX_COL, 8'h04, 8'h33);
		ext_read(horizontal_timing_pkg::IDX_HSYNC_START_LOW, 8'h06);
		sel = 1'b0;
		crtc_write(horizontal_timing_pkg::CRTC_INDEX_MONO, 8'h04, 8'h44);
		ext_read(horizontal_timing_pkg::IDX_HSYNC_START_LOW, 8'h44);
		crtc_write(horizontal_timing_pkg::CRTC_INDEX_COL, 8'h04, 8'h55);
		ext_read(horizontal_timing_pkg::IDX_HSYNC_START_LOW, 8'h55);
		complete_run();
	end
endmodule : tb_hblank_hsync_timing

/* File: window_pulse.sv */
// Registered pulse that starts on a full position match and ends on a low-bit match.
`timescale 1ns/1ps
module window_pulse #(
	parameter int END_W = 6
) (
	input  wire logic                                       clock_i,
	input  wire logic                                       rst_i,
	input  wire logic [horizontal_timing_pkg::COUNT_W-1:0]  count_i,
	input  wire logic [horizontal_timing_pkg::POS_W-1:0]    start_i,
	input  wire logic [END_W-1:0]                           end_i,
	output logic                                            active_o
);

	wire logic start_hit;
	wire logic end_hit;
	wire logic next_active;

	// Only the low END_W bits are compared, so the pulse is at most 2**END_W wide.
	assign start_hit   = (count_i == {1'b0, start_i});     // R7 R12
	assign end_hit     = (count_i[END_W-1:0] == end_i);    // R3 R9
	assign next_active = start_hit ? 1'b1 : (end_hit ? 1'b0 : active_o);

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			active_o <= 1'b0;
		end else begin
			active_o <= next_active;
		end
	end

	chk_start_sets_pulse: assert property (@(posedge clock_i) disable iff (rst_i)
		start_hit |=> active_o) else $error("pulse did not start on match"); // R12
	chk_end_clears_pulse: assert property (@(posedge clock_i) disable iff (rst_i)
		active_o && end_hit && !start_hit |=> !active_o) else $error("pulse did not end"); // R9
	chk_pulse_holds: assert property (@(posedge clock_i) disable iff (rst_i)
		!start_hit && !end_hit |=> $stable(active_o)) else $error("pulse changed unprompted"); // R3

endmodule : window_pulse
